/* File: flash_cfg_pkg.sv */
// Constants and types for the flash configuration and protection block
// Function
// - Factory test register reads zero, ignores writes
// - Config register: only enables and gate writable
// - Key gate writable only with key enabled
// - Buffer-empty enable gates buffer-empty interrupt request
// - Done enable gates all-commands-done interrupt request
// - Key gate routes array writes to key
// - Protection register readable in all modes
// - Protection polarity only clears, never sets
// - Low size writable only while low disabled
// - High size writable only while high disabled
// - Protection loaded from flash byte at reset
// - Protected program or erase refused, violation flagged
// - Mass erase only with protection fully open
// - Polarity swaps the enabled ranges between protected and open
// - High disable bit zero enables high range
// - Low disable bit zero enables low range
// - High size selects 2 to 16 Kbytes
// - Low size selects 512 bytes to 4 Kbytes
// - Writes that remove protection are ignored whole
package flash_cfg_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_TEST = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_CFG = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_PROT = 4'h4;
  localparam int BUF_IRQ_BIT = 7;
  localparam int DONE_IRQ_BIT = 6;
  localparam int KEY_GATE_BIT = 5;
  localparam int POLARITY_BIT = 7;
  localparam int HIGH_DIS_BIT = 5;
  localparam int HIGH_SIZE_LSB = 3;
  localparam int LOW_DIS_BIT = 2;
  localparam int LOW_SIZE_LSB = 0;
  localparam logic [DATA_W-1:0] PROT_RESET = 8'hFF;
  localparam logic [15:0] PROT_NV_ADDR = 16'hFF0D;
  localparam logic [1:0] KEY_ENABLED = 2'h2;
  localparam logic [15:0] LOW_BASE = 16'h4000;
  localparam logic [0:3][15:0] HIGH_BASE = {16'hF800, 16'hF000, 16'hE000, 16'hC000};
  localparam logic [0:3][15:0] LOW_LAST = {16'h41FF, 16'h43FF, 16'h47FF, 16'h4FFF};
  // Scenario = {polarity, high disable, low disable}; bit j of row i allows i to j
  localparam logic [0:7][7:0] SCEN_ALLOWED = {8'h0F, 8'h0A, 8'h0C, 8'h08,
                                              8'h18, 8'h3C, 8'h5A, 8'hFF};
  typedef enum logic {ST_LOAD = 1'b0, ST_RUN = 1'b1} boot_state_t;
endpackage

/* File: flash_config_and_protection.sv */
// Flash configuration register and range protection logic
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module flash_config_and_protection (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [flash_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [flash_cfg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [flash_cfg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [1:0] backdoor_key_enable_field,
  input wire logic buffer_empty_flag,
  input wire logic all_commands_done_flag,
  output logic buffer_empty_irq,
  output logic cmd_done_irq,
  output logic nv_rd_req,
  output logic [15:0] nv_rd_addr,
  input wire logic nv_rd_valid,
  input wire logic [flash_cfg_pkg::DATA_W-1:0] nv_rd_data,
  output logic op_ready,
  input wire logic array_wr,
  output logic cmd_seq_start,
  output logic key_word_write,
  output logic array_read_invalid,
  input wire logic cmd_req,
  input wire logic [15:0] cmd_addr,
  input wire logic cmd_is_mass,
  output logic cmd_go,
  output logic protect_violation_set
);
  import flash_cfg_pkg::*;

  boot_state_t state;
  logic running;
  logic buffer_empty_irq_enable;
  logic cmd_done_irq_enable;
  logic backdoor_key_gate;
  logic [DATA_W-1:0] prot;
  logic [DATA_W-1:0] next_prot;
  logic wr_cfg;
  logic wr_prot;
  logic key_enabled;
  logic prot_ok;
  logic protection_polarity;
  logic high_range_disable;
  logic low_range_disable;
  logic [1:0] high_range_size;
  logic [1:0] low_range_size;
  logic in_high;
  logic in_low;
  logic range_hit;
  logic addr_protected;
  logic mass_open;
  logic cmd_bad;

  function automatic logic [2:0] scen(input logic [DATA_W-1:0] p);
    scen = {p[POLARITY_BIT], p[HIGH_DIS_BIT], p[LOW_DIS_BIT]};
  endfunction

  // Boot: no register writes, commands or array writes until the protection byte is in; reads still answer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_LOAD;
    end else if (clk_en) begin
      case (state)
        ST_LOAD: begin
          if (nv_rd_valid) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
    end
  end

  assign running = (state == ST_RUN);
  assign op_ready = running;
  assign nv_rd_req = (state == ST_LOAD);
  assign nv_rd_addr = PROT_NV_ADDR;

  assign wr_cfg = clk_en && running && reg_wr && (reg_addr == OFF_CFG);
  assign wr_prot = clk_en && running && reg_wr && (reg_addr == OFF_PROT);
  assign key_enabled = (backdoor_key_enable_field == KEY_ENABLED);

  // Configuration register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buffer_empty_irq_enable <= 1'b0;
      cmd_done_irq_enable <= 1'b0;
      backdoor_key_gate <= 1'b0;
    end else if (wr_cfg) begin
      buffer_empty_irq_enable <= reg_wdata[BUF_IRQ_BIT];
      cmd_done_irq_enable <= reg_wdata[DONE_IRQ_BIT];
      if (key_enabled) begin
        backdoor_key_gate <= reg_wdata[KEY_GATE_BIT];
      end
    end
  end

  // Candidate value after a write, before the scenario check
  always_comb begin
    next_prot = prot;
    next_prot[POLARITY_BIT] = prot[POLARITY_BIT] & reg_wdata[POLARITY_BIT];
    next_prot[HIGH_DIS_BIT] = reg_wdata[HIGH_DIS_BIT];
    next_prot[LOW_DIS_BIT] = reg_wdata[LOW_DIS_BIT];
    if (prot[HIGH_DIS_BIT]) begin
      next_prot[HIGH_SIZE_LSB+:2] = reg_wdata[HIGH_SIZE_LSB+:2];
    end
    if (prot[LOW_DIS_BIT]) begin
      next_prot[LOW_SIZE_LSB+:2] = reg_wdata[LOW_SIZE_LSB+:2];
    end
  end

  assign prot_ok = SCEN_ALLOWED[scen(prot)][scen(next_prot)];

  // Spare bit keeps its loaded value; software cannot touch it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prot <= PROT_RESET;
    end else if (clk_en) begin
      if (state == ST_LOAD && nv_rd_valid) begin
        prot <= nv_rd_data;
      end else if (wr_prot && prot_ok) begin
        prot <= next_prot;
      end
    end
  end

  assign protection_polarity = prot[POLARITY_BIT];
  assign high_range_disable = prot[HIGH_DIS_BIT];
  assign low_range_disable = prot[LOW_DIS_BIT];
  assign high_range_size = prot[HIGH_SIZE_LSB+:2];
  assign low_range_size = prot[LOW_SIZE_LSB+:2];

  assign in_high = (cmd_addr >= HIGH_BASE[high_range_size]);
  assign in_low = (cmd_addr >= LOW_BASE) && (cmd_addr <= LOW_LAST[low_range_size]);
  assign range_hit = (!high_range_disable && in_high) || (!low_range_disable && in_low);
  // Closed polarity: the ranges are the only open holes in a locked array
  assign addr_protected = protection_polarity ? range_hit : !range_hit;
  assign mass_open = protection_polarity && high_range_disable && low_range_disable;
  assign cmd_bad = cmd_is_mass ? !mass_open : addr_protected;

  // Command screening; one pulse per request, either go or violation
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_go <= 1'b0;
      protect_violation_set <= 1'b0;
    end else if (clk_en) begin
      cmd_go <= cmd_req && running && !cmd_bad;
      protect_violation_set <= cmd_req && running && cmd_bad;
    end
  end

  // Array write routing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_seq_start <= 1'b0;
      key_word_write <= 1'b0;
    end else if (clk_en) begin
      cmd_seq_start <= array_wr && running && !backdoor_key_gate;
      key_word_write <= array_wr && running && backdoor_key_gate;
    end
  end

  assign array_read_invalid = backdoor_key_gate;

  // Interrupt requests follow flags a cycle late to keep outputs registered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buffer_empty_irq <= 1'b0;
      cmd_done_irq <= 1'b0;
    end else if (clk_en) begin
      buffer_empty_irq <= buffer_empty_irq_enable && buffer_empty_flag;
      cmd_done_irq <= cmd_done_irq_enable && all_commands_done_flag;
    end
  end

  // Read port, data valid only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          OFF_TEST: reg_rdata <= 8'h00;
          OFF_CFG: reg_rdata <= {buffer_empty_irq_enable, cmd_done_irq_enable,
                                 backdoor_key_gate, 5'h00};
          OFF_PROT: reg_rdata <= prot;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_boot_load;
    clk_en && state == ST_LOAD && nv_rd_valid;
  endsequence

  sequence s_cmd_single;
    clk_en && running && cmd_req && !cmd_is_mass;
  endsequence

  sequence s_cmd_mass;
    clk_en && running && cmd_req && cmd_is_mass;
  endsequence

  a_test_reg_zero: assert property (
    clk_en && reg_rd && reg_addr == OFF_TEST |=> reg_rdata == 8'h00)
    else $error("factory test register read not zero");
  a_cfg_readback: assert property (
    clk_en && reg_rd && reg_addr == OFF_CFG |=> reg_rdata[4:0] == 5'h00 &&
    reg_rdata[7:5] == $past({buffer_empty_irq_enable, cmd_done_irq_enable,
                             backdoor_key_gate}))
    else $error("config readback wrong");
  a_key_gate_lock: assert property (
    clk_en && backdoor_key_enable_field != KEY_ENABLED |=> $stable(backdoor_key_gate))
    else $error("key gate changed while key disabled");
  a_buf_irq_gate: assert property (
    clk_en && !buffer_empty_irq_enable |=> !buffer_empty_irq)
    else $error("buffer empty irq while disabled");
  a_done_irq_gate: assert property (
    clk_en && cmd_done_irq_enable && all_commands_done_flag |=> cmd_done_irq)
    else $error("done irq missing");
  a_key_route: assert property (
    clk_en && running && array_wr |=> key_word_write == $past(backdoor_key_gate) &&
    cmd_seq_start == !$past(backdoor_key_gate))
    else $error("array write misrouted");
  a_prot_readback: assert property (
    clk_en && reg_rd && reg_addr == OFF_PROT |=> reg_rdata == $past(prot))
    else $error("protection readback wrong");
  a_polarity_one_way: assert property (
    running && !protection_polarity |=> !protection_polarity)
    else $error("polarity set after clear");
  a_low_size_frozen: assert property (
    running && !low_range_disable |=> $stable(low_range_size))
    else $error("low size changed while enabled");
  a_high_size_frozen: assert property (
    running && !high_range_disable |=> $stable(high_range_size))
    else $error("high size changed while enabled");
  a_boot_load: assert property (
    s_boot_load |=> running && prot == $past(nv_rd_data))
    else $error("protection byte not loaded");
  a_violation_flag: assert property (
    s_cmd_single ##0 addr_protected |=> protect_violation_set && !cmd_go)
    else $error("protected access not refused");
  a_mass_erase: assert property (
    s_cmd_mass |=> cmd_go == $past(mass_open) && protect_violation_set == !$past(mass_open))
    else $error("mass erase screening wrong");
  a_no_loosen: assert property (
    running && $past(running) && prot != $past(prot) |->
    SCEN_ALLOWED[scen($past(prot))][scen(prot)])
    else $error("illegal protection transition");
endmodule

/* File: flash_nv_model.sv */
// Flash array model returning the stored protection byte after reset
`timescale 1ns/1ps
module flash_nv_model #(
  parameter int LAT = 3,
  // Byte the controller programmed after unprotecting the top sector
  parameter logic [7:0] PROT_BYTE = 8'hFF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic nv_rd_req,
  input wire logic [15:0] nv_rd_addr,
  output logic nv_rd_valid,
  output logic [7:0] nv_rd_data
);
  int cnt;
  logic [7:0] stored;
  // Spare bit 6 of the stored byte left erased
  assign stored = (nv_rd_addr == 16'hFF0D) ? PROT_BYTE : 8'h00;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      nv_rd_valid <= 1'b0;
      nv_rd_data <= 8'h00;
    end else if (nv_rd_req && !nv_rd_valid && cnt == LAT) begin
      nv_rd_valid <= 1'b1;
      nv_rd_data <= stored;
    end else begin
      cnt <= nv_rd_req ? cnt + 1 : 0;
      nv_rd_valid <= 1'b0;
      // Released data toggles so a stale byte is never mistaken
      nv_rd_data <= ~nv_rd_data;
    end
  end
endmodule

/* File: tb.sv */
// Self-checking bench for the flash configuration and protection block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
  import flash_cfg_pkg::*;
  logic mclk, rst, clk_en, reg_wr, reg_rd, buf_flag, done_flag, array_wr, cmd_req, cmd_mass;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, nv_rd_data;
  logic [1:0] key_field;
  logic [15:0] nv_rd_addr, cmd_addr;
  logic buf_irq, done_irq, nv_rd_req, nv_rd_valid, op_ready, seq_start, key_wr, rd_inv, go, viol;
  int num_errors = 0;
  int checks_done = 0;

  flash_config_and_protection dut (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .backdoor_key_enable_field(key_field),
    .buffer_empty_flag(buf_flag), .all_commands_done_flag(done_flag),
    .buffer_empty_irq(buf_irq), .cmd_done_irq(done_irq), .nv_rd_req(nv_rd_req),
    .nv_rd_addr(nv_rd_addr), .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data),
    .op_ready(op_ready), .array_wr(array_wr), .cmd_seq_start(seq_start),
    .key_word_write(key_wr), .array_read_invalid(rd_inv), .cmd_req(cmd_req),
    .cmd_addr(cmd_addr), .cmd_is_mass(cmd_mass), .cmd_go(go), .protect_violation_set(viol));
  flash_nv_model #(.LAT(3), .PROT_BYTE(8'hFF)) nvm (.mclk(mclk), .rst(rst),
    .nv_rd_req(nv_rd_req), .nv_rd_addr(nv_rd_addr), .nv_rd_valid(nv_rd_valid),
    .nv_rd_data(nv_rd_data));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask

  task automatic pw(input logic [7:0] d, input logic [7:0] e);
    wr(OFF_PROT, d);
    rdchk("prot", OFF_PROT, e);
  endtask

  task automatic cmdchk(input logic [15:0] a, input logic mass, input logic ok);
    @(posedge mclk);
    cmd_addr <= a;
    cmd_mass <= mass;
    cmd_req <= 1'b1;
    @(posedge mclk);
    cmd_req <= 1'b0;
    #1;
    `CHK("cmd_go", ok, go)
    `CHK("violation", ~ok, viol)
  endtask

  task automatic t_prot();
    rdchk("prot_boot", OFF_PROT, 8'hFF);
    pw(8'hE4, 8'hE4);
    cmdchk(16'h0000, 1'b1, 1'b1);
    pw(8'hC4, 8'hC4);
    pw(8'hDC, 8'hC4);
    cmdchk(16'hF800, 1'b0, 1'b0);
    cmdchk(16'hF7FF, 1'b0, 1'b1);
    cmdchk(16'h4000, 1'b1, 1'b0);
    pw(8'hE4, 8'hC4);
    pw(8'hC1, 8'hC1);
    cmdchk(16'h43FF, 1'b0, 1'b0);
    cmdchk(16'h4400, 1'b0, 1'b1);
    pw(8'h41, 8'hC1);
    pw(8'h24, 8'h65);
    cmdchk(16'h8000, 1'b0, 1'b0);
    pw(8'hE5, 8'h65);
    $display("protection test done");
  endtask

  task automatic t_cfg();
    wr(OFF_TEST, 8'hFF);
    rdchk("test_reg", OFF_TEST, 8'h00);
    rdchk("unmapped", 4'hF, 8'h00);
    for (int k = 0; k < 4; k++) begin
      key_field <= k[1:0];
      wr(OFF_CFG, 8'hFF);
      rdchk("cfg", OFF_CFG, {2'b11, k == 2, 5'h00});
      key_field <= 2'h2;
      wr(OFF_CFG, 8'h00);
    end
    // Clock enable low must freeze the register against a write
    clk_en <= 1'b0;
    wr(OFF_CFG, 8'hE0);
    clk_en <= 1'b1;
    rdchk("cfg_frozen", OFF_CFG, 8'h00);
    $display("config test done");
  endtask

  task automatic t_irq();
    wr(OFF_CFG, 8'hC0);
    for (int i = 1; i < 4; i++) begin
      {buf_flag, done_flag} <= i[1:0];
      repeat (2) @(posedge mclk);
      #1;
      `CHK("buf_irq", i[1], buf_irq)
      `CHK("done_irq", i[0], done_irq)
    end
    wr(OFF_CFG, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("buf_irq_off", 1'b0, buf_irq)
    `CHK("done_irq_off", 1'b0, done_irq)
    $display("interrupt test done");
  endtask

  task automatic t_array();
    for (int g = 0; g < 2; g++) begin
      wr(OFF_CFG, {2'b00, g[0], 5'h00});
      @(posedge mclk);
      array_wr <= 1'b1;
      @(posedge mclk);
      array_wr <= 1'b0;
      #1;
      `CHK("key_word", g[0], key_wr)
      `CHK("seq_start", ~g[0], seq_start)
      `CHK("rd_invalid", g[0], rd_inv)
    end
    $display("array routing test done");
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    {rst, clk_en, reg_wr, reg_rd, buf_flag, done_flag, array_wr, cmd_req, cmd_mass} = 9'h180;
    {reg_addr, reg_wdata, key_field, cmd_addr} = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    #1;
    `CHK("nv_req", 1'b1, nv_rd_req)
    `CHK("nv_addr", PROT_NV_ADDR, nv_rd_addr)
    // Bounded wait so a stuck load cannot hang the run
    for (int i = 0; i < 100 && op_ready !== 1'b1; i++) @(posedge mclk);
    if (op_ready !== 1'b1) begin
      num_errors++;
      conclude();
    end
    t_prot();
    t_cfg();
    t_irq();
    t_array();
    conclude();
  end
endmodule
